// ---- verilog/iprg_cfg.svh ----
// Notes on behaviour
// - a field code of all ones selects level 7, the highest user level
// - a field code of all zeros disables its source: from one cycle after the write it never requests
// - code one is level 1, the lowest; codes two to six map straight through
// - bits outside the priority fields read back as zero
// - at reset each field's top bit is one and its two lower bits zero
// - so every source leaves reset at priority level 4
// - rtc register: rtc source priority in bits 10-8, nothing else
// - crc/uart error register: crc 14-12, uart2 error 10-8, uart1 error 6-4
// - low-voltage register: low-voltage priority in bits 2-0 only
// - capacitive measure register: its priority in bits 6-4 only
// - uart3 register: transmit 14-12, receive 10-8, error 6-4
// - uart4 error/i2c3 register: uart4 error 14-12, master 6-4, slave 2-0
// - spi3/uart4 register: event 14-12, fault 10-8, tx 6-4, rx 2-0
`ifndef IPRG_CFG_SVH
`define IPRG_CFG_SVH

`define IPRG_RTC_OFFSET 12'h03C
`define IPRG_CRC_UART_OFFSET 12'h040
`define IPRG_LOW_VOLT_OFFSET 12'h048
`define IPRG_CAP_OFFSET 12'h04C
`define IPRG_UART3_OFFSET 12'h050
`define IPRG_U4_I2C3_OFFSET 12'h054
`define IPRG_SPI3_U4_OFFSET 12'h058
`define IPRG_ACTIVE_OFFSET 12'h060
`define IPRG_REQUEST_OFFSET 12'h064

`define IPRG_FIELD_W 3
`define IPRG_REG_W 16
`define IPRG_PRIO_RESET 3'h4
`define IPRG_PRIO_OFF 3'h0

`define IPRG_RTC_LSB 8
`define IPRG_CRC_LSB 12
`define IPRG_UART2_ERR_LSB 8
`define IPRG_UART1_ERR_LSB 4
`define IPRG_LOW_VOLT_LSB 0
`define IPRG_CAP_LSB 4
`define IPRG_UART3_TX_LSB 12
`define IPRG_UART3_RX_LSB 8
`define IPRG_UART3_ERR_LSB 4
`define IPRG_UART4_ERR_LSB 12
`define IPRG_I2C3_MASTER_LSB 4
`define IPRG_I2C3_SLAVE_LSB 0
`define IPRG_SPI3_EVENT_LSB 12
`define IPRG_SPI3_FAULT_LSB 8
`define IPRG_UART4_TX_LSB 4
`define IPRG_UART4_RX_LSB 0

`endif

// ---- verilog/iprg_pkg.sv ----
package iprg_pkg;
    typedef logic [2:0] iprg_prio_t;
    typedef enum logic [3:0] {
        IPRG_SEL_NONE = 4'h0,
        IPRG_SEL_RTC = 4'h1,
        IPRG_SEL_CRC_UART = 4'h2,
        IPRG_SEL_LOW_VOLT = 4'h3,
        IPRG_SEL_CAP = 4'h4,
        IPRG_SEL_UART3 = 4'h5,
        IPRG_SEL_U4_I2C3 = 4'h6,
        IPRG_SEL_SPI3_U4 = 4'h7,
        IPRG_SEL_ACTIVE = 4'h8,
        IPRG_SEL_REQUEST = 4'h9
    } iprg_sel_t;
endpackage

// ---- verilog/iprg_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface iprg_field_if;
    import iprg_pkg::*;
    logic we;
    iprg_prio_t wdata;
    iprg_prio_t value;
    modport owner (input we, input wdata, output value);
    modport bank (output we, output wdata, input value);
endinterface

interface iprg_bus_if;
    import iprg_pkg::*;
    logic wr_en;
    logic [1:0] lane_en;
    logic [15:0] wdata;
    iprg_sel_t sel;
    logic [15:0] rdata;
    modport slave (output wr_en, output lane_en, output wdata, output sel,
                   input rdata);
    modport bank (input wr_en, input lane_en, input wdata, input sel,
                  output rdata);
endinterface
`default_nettype wire

// ---- verilog/iprg_prio_field.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "iprg_cfg.svh"
module iprg_prio_field
    import iprg_pkg::*;
(
    input wire logic pclk,        // system clock
    input wire logic presetn,     // async reset, active low
    iprg_field_if.owner fif       // write port and stored level
);
    // level 4 after reset; stored code is the level itself
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fif.value <= `IPRG_PRIO_RESET;
        end else if (fif.we) begin
            fif.value <= fif.wdata;
        end
    end
endmodule
`default_nettype wire

// ---- verilog/iprg_apb_slave.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "iprg_cfg.svh"
module iprg_apb_slave
    import iprg_pkg::*;
(
    input wire logic pclk,           // system clock
    input wire logic presetn,        // async reset, active low
    input wire logic [11:0] paddr,   // byte address
    input wire logic psel,           // slave select
    input wire logic penable,        // access phase
    input wire logic pwrite,         // 1 = write
    input wire logic [31:0] pwdata,  // write data
    input wire logic [3:0] pstrb,    // byte lane strobes
    output logic [31:0] prdata,      // read data, registered
    output logic pready,             // always ready
    output logic pslverr,            // unmapped address, registered
    iprg_bus_if.slave bus            // toward the register bank
);
    iprg_sel_t sel_now;

    always_comb begin
        unique case (paddr)
            `IPRG_RTC_OFFSET: sel_now = IPRG_SEL_RTC;
            `IPRG_CRC_UART_OFFSET: sel_now = IPRG_SEL_CRC_UART;
            `IPRG_LOW_VOLT_OFFSET: sel_now = IPRG_SEL_LOW_VOLT;
            `IPRG_CAP_OFFSET: sel_now = IPRG_SEL_CAP;
            `IPRG_UART3_OFFSET: sel_now = IPRG_SEL_UART3;
            `IPRG_U4_I2C3_OFFSET: sel_now = IPRG_SEL_U4_I2C3;
            `IPRG_SPI3_U4_OFFSET: sel_now = IPRG_SEL_SPI3_U4;
            `IPRG_ACTIVE_OFFSET: sel_now = IPRG_SEL_ACTIVE;
            `IPRG_REQUEST_OFFSET: sel_now = IPRG_SEL_REQUEST;
            default: sel_now = IPRG_SEL_NONE;
        endcase
    end

    assign bus.sel = sel_now;
    assign bus.wdata = pwdata[15:0];
    assign bus.lane_en = pstrb[1:0];
    assign bus.wr_en = psel & penable & pwrite & (sel_now != IPRG_SEL_NONE);
    assign pready = 1'b1;

    // capture in the setup cycle so the answer is a flop in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : {16'h0000, bus.rdata};
            pslverr <= (sel_now == IPRG_SEL_NONE);
        end
    end
endmodule
`default_nettype wire

// ---- verilog/iprg_regs.sv ----
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "iprg_cfg.svh"
module iprg_regs
    import iprg_pkg::*;
#(
    parameter int NUM_SRC = 16       // priority fields in the bank
)
(
    input wire logic pclk,           // system clock
    input wire logic presetn,        // async reset, active low
    input wire logic [11:0] paddr,   // apb byte address
    input wire logic psel,           // apb select
    input wire logic penable,        // apb access phase
    input wire logic pwrite,         // apb direction, 1 = write
    input wire logic [31:0] pwdata,  // apb write data
    input wire logic [3:0] pstrb,    // apb byte strobes
    output logic [31:0] prdata,      // apb read data
    output logic pready,             // apb ready
    output logic pslverr,            // apb error on unmapped address
    input wire logic [NUM_SRC-1:0] src_pending,  // flag and enable per source
    output logic [NUM_SRC-1:0] src_request,      // pending and not disabled
    output iprg_prio_t rtc_source_priority,         // real-time clock
    output iprg_prio_t crc_error_source_priority,   // crc error
    output iprg_prio_t uart2_error_priority,        // uart2 error
    output iprg_prio_t uart1_error_priority,        // uart1 error
    output iprg_prio_t low_voltage_source_priority, // low-voltage detect
    output iprg_prio_t cap_measure_source_priority, // capacitive measure
    output iprg_prio_t uart3_tx_priority,           // uart3 transmit
    output iprg_prio_t uart3_rx_priority,           // uart3 receive
    output iprg_prio_t uart3_error_priority,        // uart3 error
    output iprg_prio_t uart4_error_priority,        // uart4 error
    output iprg_prio_t i2c3_master_priority,        // i2c3 master event
    output iprg_prio_t i2c3_slave_priority,         // i2c3 slave event
    output iprg_prio_t spi3_event_priority,         // spi3 event
    output iprg_prio_t spi3_fault_priority,         // spi3 fault
    output iprg_prio_t uart4_tx_priority,           // uart4 transmit
    output iprg_prio_t uart4_rx_priority            // uart4 receive
);
    // index order matches the src_pending / src_request bit order
    localparam iprg_sel_t FIELD_REG [16] = '{
        IPRG_SEL_RTC,
        IPRG_SEL_CRC_UART,
        IPRG_SEL_CRC_UART,
        IPRG_SEL_CRC_UART,
        IPRG_SEL_LOW_VOLT,
        IPRG_SEL_CAP,
        IPRG_SEL_UART3,
        IPRG_SEL_UART3,
        IPRG_SEL_UART3,
        IPRG_SEL_U4_I2C3,
        IPRG_SEL_U4_I2C3,
        IPRG_SEL_U4_I2C3,
        IPRG_SEL_SPI3_U4,
        IPRG_SEL_SPI3_U4,
        IPRG_SEL_SPI3_U4,
        IPRG_SEL_SPI3_U4
    };

    localparam int FIELD_LSB [16] = '{
        `IPRG_RTC_LSB,
        `IPRG_CRC_LSB,
        `IPRG_UART2_ERR_LSB,
        `IPRG_UART1_ERR_LSB,
        `IPRG_LOW_VOLT_LSB,
        `IPRG_CAP_LSB,
        `IPRG_UART3_TX_LSB,
        `IPRG_UART3_RX_LSB,
        `IPRG_UART3_ERR_LSB,
        `IPRG_UART4_ERR_LSB,
        `IPRG_I2C3_MASTER_LSB,
        `IPRG_I2C3_SLAVE_LSB,
        `IPRG_SPI3_EVENT_LSB,
        `IPRG_SPI3_FAULT_LSB,
        `IPRG_UART4_TX_LSB,
        `IPRG_UART4_RX_LSB
    };

    iprg_bus_if bus ();
    iprg_field_if fif [NUM_SRC] ();

    logic [15:0] contrib [NUM_SRC];
    iprg_prio_t level [NUM_SRC];
    logic [NUM_SRC-1:0] src_active;
    logic [NUM_SRC-1:0] src_request_reg;
    logic [15:0] field_rdata;

    iprg_apb_slave u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .bus(bus.slave)
    );

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi++) begin : g_field
            // a field never straddles a byte lane, so one strobe covers it;
            // writes carry only the field's own bits, so unused bits are lost
            assign fif[gi].we = bus.wr_en
                && (bus.sel == FIELD_REG[gi])
                && bus.lane_en[FIELD_LSB[gi] / 8];
            assign fif[gi].wdata = bus.wdata[FIELD_LSB[gi] +: 3];
            assign level[gi] = fif[gi].value;
            // zero code means the source is switched off entirely
            assign src_active[gi] = (fif[gi].value != `IPRG_PRIO_OFF);
            // place the field at its bit position; other bits stay zero
            assign contrib[gi] = (bus.sel == FIELD_REG[gi])
                ? (16'(fif[gi].value) << FIELD_LSB[gi]) : 16'h0000;

            iprg_prio_field u_field (
                .pclk(pclk),
                .presetn(presetn),
                .fif(fif[gi].owner)
            );
        end
    endgenerate

    always_comb begin
        field_rdata = 16'h0000;
        for (int i = 0; i < NUM_SRC; i++) begin
            field_rdata = field_rdata | contrib[i];
        end
    end

    // the two summary words expose the bank's own state to software
    always_comb begin
        unique case (bus.sel)
            IPRG_SEL_ACTIVE: bus.rdata = 16'(src_active);
            IPRG_SEL_REQUEST: bus.rdata = 16'(src_request_reg);
            default: bus.rdata = field_rdata;
        endcase
    end

    // registered so arbitration sees a glitch-free level; costs one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_request_reg <= '0;
        end else begin
            src_request_reg <= src_pending & src_active;
        end
    end

    assign src_request = src_request_reg;

    // fields drive arbitration straight from their flops at all times
    assign rtc_source_priority = level[0];
    assign crc_error_source_priority = level[1];
    assign uart2_error_priority = level[2];
    assign uart1_error_priority = level[3];
    assign low_voltage_source_priority = level[4];
    assign cap_measure_source_priority = level[5];
    assign uart3_tx_priority = level[6];
    assign uart3_rx_priority = level[7];
    assign uart3_error_priority = level[8];
    assign uart4_error_priority = level[9];
    assign i2c3_master_priority = level[10];
    assign i2c3_slave_priority = level[11];
    assign spi3_event_priority = level[12];
    assign spi3_fault_priority = level[13];
    assign uart4_tx_priority = level[14];
    assign uart4_rx_priority = level[15];
endmodule
`default_nettype wire

// ---- bench/iprg_regs_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module iprg_regs_sva
    import iprg_pkg::*;
#(
    parameter int NUM_SRC = 16 // priority fields
)
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic [11:0] paddr, // address
    input wire logic psel, // select
    input wire logic penable, // access phase
    input wire logic pwrite, // direction
    input wire logic [31:0] pwdata, // write data
    input wire logic [3:0] pstrb, // strobes
    input wire logic [31:0] prdata, // read data
    input wire logic [NUM_SRC-1:0] src_pending, // pending
    input wire logic [NUM_SRC-1:0] src_request, // request
    input wire iprg_prio_t rtc_source_priority, // rtc level
    input wire iprg_prio_t low_voltage_source_priority // low-voltage level
);
    logic [31:0] wd_q;
    logic req_q;
    // write data seen one edge late, for the field compare
    always_ff @(posedge pclk) wd_q <= pwdata;
    always_ff @(posedge pclk) req_q <= src_pending[0] &&
        rtc_source_priority != 3'h0;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence acc_rd;
        psel && penable && !pwrite;
    endsequence
    sequence acc_wr;
        psel && penable && pwrite;
    endsequence
    sequence wr_rtc;
        acc_wr ##0 (paddr == 12'h03C && pstrb[1]);
    endsequence
    sequence wr_lv;
        acc_wr ##0 (paddr == 12'h048 && pstrb[0]);
    endsequence
    reset_level_a: assert property ($rose(presetn) |->
        rtc_source_priority == 3'h4 && low_voltage_source_priority == 3'h4)
        else $error("priority not at reset level");
    upper_zero_a: assert property (acc_rd |->
        prdata[31:16] == 16'h0000) else $error("upper read bits set");
    rtc_read_a: assert property (acc_rd ##0 paddr == 12'h03C |->
        prdata[15:0] == {5'h00, $past(rtc_source_priority), 8'h00})
        else $error("rtc read mismatch");
    lv_read_a: assert property (acc_rd ##0 paddr == 12'h048 |->
        prdata[15:0] == {13'h0000, $past(low_voltage_source_priority)})
        else $error("low-voltage read mismatch");
    rtc_write_a: assert property (wr_rtc |=>
        rtc_source_priority == wd_q[10:8]) else $error("rtc write lost");
    lv_write_a: assert property (wr_lv |=>
        low_voltage_source_priority == wd_q[2:0])
        else $error("low-voltage write lost");
    rtc_hold_a: assert property (!(psel && penable && pwrite &&
        paddr == 12'h03C) |=> $stable(rtc_source_priority))
        else $error("rtc level changed without write");
    request_gate_a: assert property ($past(presetn) |->
        src_request[0] == req_q) else $error("request gating wrong");
endmodule
bind iprg_regs iprg_regs_sva #(.NUM_SRC(NUM_SRC)) chk_u (.pclk, .presetn,
    .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
    .src_pending, .src_request, .rtc_source_priority,
    .low_voltage_source_priority);
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import iprg_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [15:0] src_pending = 16'h0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] src_request;
    iprg_prio_t po [16];
    iprg_prio_t m [16];
    int miscompares = 0;
    int n_checks = 0;
    localparam logic [11:0] FA [16] = '{12'h03C, 12'h040, 12'h040, 12'h040,
        12'h048, 12'h04C, 12'h050, 12'h050, 12'h050, 12'h054, 12'h054,
        12'h054, 12'h058, 12'h058, 12'h058, 12'h058};
    localparam int FL [16] = '{8, 12, 8, 4, 0, 4, 12, 8, 4, 12, 4, 0,
        12, 8, 4, 0};
    // address, strobes, write data, expected read back
    localparam logic [47:0] ROWS [20] = '{
        48'h03C0_FFFF_0400, 48'h0400_FFFF_4440, 48'h0480_FFFF_0004,
        48'h04C0_FFFF_0040, 48'h0500_FFFF_4440, 48'h0540_FFFF_4044,
        48'h0580_FFFF_4444, 48'h03C3_FFFF_0700, 48'h0403_FFFF_7770,
        48'h0483_FFFF_0007, 48'h04C3_FFFF_0070, 48'h0503_FFFF_7770,
        48'h0543_FFFF_7077, 48'h0583_FFFF_7777, 48'h0583_1234_1234,
        48'h0543_5A6B_5063, 48'h0503_FEDC_7650, 48'h0401_0000_7700,
        48'h04C2_00FF_0070, 48'h0583_0000_0000};
    iprg_regs dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_pending(src_pending), .src_request(src_request),
        .rtc_source_priority(po[0]), .crc_error_source_priority(po[1]),
        .uart2_error_priority(po[2]), .uart1_error_priority(po[3]),
        .low_voltage_source_priority(po[4]),
        .cap_measure_source_priority(po[5]), .uart3_tx_priority(po[6]),
        .uart3_rx_priority(po[7]), .uart3_error_priority(po[8]),
        .uart4_error_priority(po[9]), .i2c3_master_priority(po[10]),
        .i2c3_slave_priority(po[11]), .spi3_event_priority(po[12]),
        .spi3_fault_priority(po[13]), .uart4_tx_priority(po[14]),
        .uart4_rx_priority(po[15]));
    always #5 pclk = ~pclk;
    task summarize;
        if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [47:0] g, input logic [47:0] e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    function logic [47:0] mvec;
        for (int i = 0; i < 16; i++) mvec[3*i+:3] = m[i];
    endfunction
    function logic [47:0] pvec;
        for (int i = 0; i < 16; i++) pvec[3*i+:3] = po[i];
    endfunction
    task xfer(input logic w, input logic [11:0] a, input logic [15:0] d,
        input logic [3:0] s, output logic [31:0] r, output logic e);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {16'h0000, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            summarize();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        // model keeps only fields whose byte lane was strobed
        if (w) for (int i = 0; i < 16; i++)
            if (FA[i] == a && s[FL[i]/8]) m[i] = d[FL[i]+:3];
    endtask
    initial begin
        logic [31:0] r;
        logic e;
        logic [15:0] xr;
        foreach (m[i]) m[i] = 3'h4;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(pvec(), mvec());
        foreach (ROWS[i]) begin
            xfer(1'b1, ROWS[i][47:36], ROWS[i][31:16], ROWS[i][35:32], r, e);
            xfer(1'b0, ROWS[i][47:36], 16'h0000, 4'h0, r, e);
            chk({16'h0000, r}, {32'h0000_0000, ROWS[i][15:0]});
            chk({32'h0000_0000, 15'h0000, e}, 48'h0000_0000_0000);
            chk(pvec(), mvec());
        end
        xfer(1'b0, 12'h044, 16'h0000, 4'h0, r, e);
        chk({15'h0000, r, e}, 48'h0000_0000_0001);
        src_pending <= 16'hFFFF;
        repeat (2) @(posedge pclk);
        foreach (m[i]) xr[i] = (m[i] != 3'h0);
        chk({32'h0000_0000, src_request}, {32'h0000_0000, xr});
        xfer(1'b0, 12'h060, 16'h0000, 4'h0, r, e);
        chk({15'h0000, r, e}, {31'h0000_0000, xr, 1'b0});
        xfer(1'b0, 12'h064, 16'h0000, 4'h0, r, e);
        chk({15'h0000, r, e}, {31'h0000_0000, xr, 1'b0});
        // status words ignore writes and raise no error
        xfer(1'b1, 12'h060, 16'hFFFF, 4'hF, r, e);
        chk({32'h0000_0000, 15'h0000, e}, 48'h0000_0000_0000);
        chk(pvec(), mvec());
        // reset in mid-run must restore level 4 at once
        presetn <= 1'b0;
        @(posedge pclk);
        foreach (m[i]) m[i] = 3'h4;
        chk(pvec(), mvec());
        chk({32'h0000_0000, src_request}, 48'h0000_0000_0000);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({32'h0000_0000, src_request}, 48'h0000_0000_FFFF);
        summarize();
    end
endmodule
`default_nettype wire
